// file: shared/jmic_pkg.sv
// constants of the joystick measurement and interrupt control block
// assumes a 100 MHz system clock and an i2c engine that supplies pointer and strobes
package jmic_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h0F;
  localparam logic [7:0] ADDR_X = 8'h10;
  localparam logic [7:0] ADDR_Y = 8'h11;
  localparam logic [7:0] ADDR_LEFT = 8'h12;
  localparam logic [7:0] ADDR_RIGHT = 8'h13;
  localparam logic [7:0] ADDR_TOP = 8'h14;
  localparam logic [7:0] ADDR_BOTTOM = 8'h15;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_IDLE_BIT = 7;
  localparam int CTRL_TB_HI = 6;
  localparam int CTRL_TB_LO = 4;
  localparam int CTRL_IRQ_DIS_BIT = 3;
  localparam int CTRL_IRQ_FN_BIT = 2;
  localparam int CTRL_SRST_BIT = 1;
  localparam int CTRL_VALID_BIT = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'hF0;
  localparam logic [7:0] LEFT_RESET = 8'h05;
  localparam logic [7:0] RIGHT_RESET = 8'hFB;
  localparam logic [7:0] TOP_RESET = 8'h05;
  localparam logic [7:0] BOTTOM_RESET = 8'hFB;
  localparam logic [7:0] COORD_RESET = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int MS_TICK_US = 1000;
  localparam int MS_TICK_CYCLES = MS_TICK_US * CLK_MHZ;
  localparam int IRQ_DELAY_US = 450;
  localparam int IRQ_DELAY_CYCLES = IRQ_DELAY_US * CLK_MHZ;
  localparam logic [2:0] SRST_CYCLES = 3'h4;
  localparam int TICK_W = 17;
  localparam int WAKE_W = 9;

  // wake interval in milliseconds per time base code
  function automatic logic [WAKE_W-1:0] wake_ms(input logic [2:0] code);
    case (code)
      3'h0: wake_ms = 9'd20;
      3'h1: wake_ms = 9'd40;
      3'h2: wake_ms = 9'd80;
      3'h3: wake_ms = 9'd100;
      3'h4: wake_ms = 9'd140;
      3'h5: wake_ms = 9'd200;
      3'h6: wake_ms = 9'd260;
      default: wake_ms = 9'd320;
    endcase
  endfunction : wake_ms

  // measurement sequencer states
  typedef enum logic [0:0] {
    JMIC_MEAS_IDLE = 1'b0,
    JMIC_MEAS_BUSY = 1'b1
  } jmic_meas_e;

endpackage : jmic_pkg

// file: verilog/jmic_wake_timer.sv
// low power wake timer: counts millisecond ticks up to the chosen interval
// assumes a one-cycle tick enable from the caller on the same clock
`timescale 1ns/1ns
module jmic_wake_timer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick_ms,
  input wire logic run,
  input wire logic [jmic_pkg::WAKE_W-1:0] interval_ms,
  output logic wake
);

  logic [jmic_pkg::WAKE_W-1:0] cnt_r;
  logic [jmic_pkg::WAKE_W-1:0] cnt_nxt;
  logic wake_r;
  logic wake_nxt;

  // ----------------------------------------------------------------
  // interval counter
  // ----------------------------------------------------------------
  // stopped timer restarts from zero; the tick divider runs on, so the first interval after a mode change can be up to one ms short
  always_comb begin
    cnt_nxt = cnt_r;
    wake_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = '0;
    end else if (tick_ms) begin
      if (cnt_r + 9'd1 >= interval_ms) begin
        cnt_nxt = '0;
        wake_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 9'd1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      wake_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign wake = wake_r;

endmodule : jmic_wake_timer

// file: verilog/jmic_control.sv
// measurement pacing, interrupt and control register logic of the joystick sensor
// assumes the i2c slave engine and the hall front end run on clk and hand over
// pointer, write strobe, y-readout ack and conversion results as plain signals
`timescale 1ns/1ns

// Functional notes
// R1: idle bit 0 selects low power mode, timer-paced by time base bits 6:4.
// R2: idle bit 1 (default) starts one measurement after the y readout acknowledge.
// R3: time base codes 0..7 give 20,40,80,100,140,200,260,320 ms; 320 default.
// R4: interrupt disable bit 3 set keeps the interrupt pin released high.
// R5: function bit 0 asserts interrupt per measurement; idle mode 450 us after readout.
// R6: interrupt releases only after the acknowledge following the y readout.
// R7: function bit 1 asserts interrupt when position lies outside the dead zone.
// R8: dead zone interrupt reasserts next measurement while position stays outside.
// R9: host should pair dead zone mode with low power mode for wake-up.
// R10: soft reset bit reloads every register, control to F0, then clears itself.
// R11: data valid reads 0 while a conversion is in progress.
// R12: data valid becomes 1 when new coordinates are available.
// R13: pointer on 0F, 10h or 11h freezes control, x and y as snapshot.
// R14: x is 8-bit two's complement, positive means movement to the left.
// R15: thresholds are 8-bit signed; left bounds positive x, right negative x.
// R16: outside when x or y passes its threshold by signed comparison.
module jmic_control #(
  parameter int MS_TICK_CYCLES = jmic_pkg::MS_TICK_CYCLES,
  parameter int IRQ_DELAY_CYCLES = jmic_pkg::IRQ_DELAY_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_ptr,
  input wire logic reg_wr_strobe,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_hit,
  input wire logic y_read_ack,
  output logic meas_start,
  input wire logic meas_done,
  input wire logic [7:0] meas_x,
  input wire logic [7:0] meas_y,
  output logic motion_irq_n_o,
  output logic motion_irq_n_oe_n
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic idle_r, idle_nxt;
  logic [2:0] tb_r, tb_nxt;
  logic irq_dis_r, irq_dis_nxt;
  logic irq_fn_r, irq_fn_nxt;
  logic [2:0] srst_cnt_r, srst_cnt_nxt;
  logic [7:0] left_r, left_nxt;
  logic [7:0] right_r, right_nxt;
  logic [7:0] top_r, top_nxt;
  logic [7:0] bottom_r, bottom_nxt;
  logic [7:0] x_r, x_nxt;
  logic [7:0] y_r, y_nxt;
  logic valid_r, valid_nxt;
  logic [7:0] snap_ctrl_r, snap_ctrl_nxt;
  logic [7:0] snap_x_r, snap_x_nxt;
  logic [7:0] snap_y_r, snap_y_nxt;
  jmic_pkg::jmic_meas_e meas_r, meas_nxt;
  logic start_r, start_nxt;
  logic boot_r, boot_nxt;
  logic irq_r, irq_nxt;
  logic pend_r, pend_nxt;
  logic [jmic_pkg::TICK_W-1:0] dly_r, dly_nxt;
  logic [jmic_pkg::TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_hit_r, rd_hit_nxt;
  logic oe_n_r, oe_n_nxt;
  logic soft_clr;
  logic wr_ctrl;
  logic frozen;
  logic outside;
  logic wake;
  logic irq_event;
  logic [7:0] ctrl_live;

  // ----------------------------------------------------------------
  // shared decode
  // ----------------------------------------------------------------
  // soft reset holds registers, sequencer and wake timer at reset values while its sequence runs
  assign soft_clr = (srst_cnt_r != 3'h0);
  assign wr_ctrl = reg_wr_strobe && (reg_ptr == jmic_pkg::ADDR_CTRL);
  assign frozen = (reg_ptr == jmic_pkg::ADDR_CTRL) || (reg_ptr == jmic_pkg::ADDR_X) ||
                  (reg_ptr == jmic_pkg::ADDR_Y); // R13
  // signed dead zone test on the fresh conversion result
  assign outside = ($signed(meas_x) > $signed(left_r)) || ($signed(meas_x) < $signed(right_r)) ||
                   ($signed(meas_y) > $signed(top_r)) || ($signed(meas_y) < $signed(bottom_r)); // R15 R16
  assign ctrl_live = {idle_r, tb_r, irq_dis_r, irq_fn_r, soft_clr, valid_r};

  // ----------------------------------------------------------------
  // millisecond tick and wake timer
  // ----------------------------------------------------------------
  // one shared divider; the wake timer counts whole milliseconds
  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 17'd1;
    if (tick_cnt_r == MS_TICK_CYCLES[jmic_pkg::TICK_W-1:0] - 17'd1) begin
      tick_cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  jmic_wake_timer u_jmic_wake_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick_ms(tick_r),
    .run(!idle_r && !soft_clr), // R1
    .interval_ms(jmic_pkg::wake_ms(tb_r)), // R3
    .wake(wake)
  );

  // ----------------------------------------------------------------
  // configuration registers and soft reset
  // ----------------------------------------------------------------
  // data valid is read only, so bit 0 of a control write is dropped
  always_comb begin
    idle_nxt = idle_r;
    tb_nxt = tb_r;
    irq_dis_nxt = irq_dis_r;
    irq_fn_nxt = irq_fn_r;
    left_nxt = left_r;
    right_nxt = right_r;
    top_nxt = top_r;
    bottom_nxt = bottom_r;
    srst_cnt_nxt = srst_cnt_r;
    if (soft_clr) begin
      // R10
      idle_nxt = jmic_pkg::CTRL_RESET[jmic_pkg::CTRL_IDLE_BIT];
      tb_nxt = jmic_pkg::CTRL_RESET[jmic_pkg::CTRL_TB_HI:jmic_pkg::CTRL_TB_LO];
      irq_dis_nxt = jmic_pkg::CTRL_RESET[jmic_pkg::CTRL_IRQ_DIS_BIT];
      irq_fn_nxt = jmic_pkg::CTRL_RESET[jmic_pkg::CTRL_IRQ_FN_BIT];
      left_nxt = jmic_pkg::LEFT_RESET;
      right_nxt = jmic_pkg::RIGHT_RESET;
      top_nxt = jmic_pkg::TOP_RESET;
      bottom_nxt = jmic_pkg::BOTTOM_RESET;
      srst_cnt_nxt = srst_cnt_r - 3'h1; // R10
    end else if (wr_ctrl) begin
      idle_nxt = reg_wr_data[jmic_pkg::CTRL_IDLE_BIT]; // R1 R2
      tb_nxt = reg_wr_data[jmic_pkg::CTRL_TB_HI:jmic_pkg::CTRL_TB_LO]; // R3
      irq_dis_nxt = reg_wr_data[jmic_pkg::CTRL_IRQ_DIS_BIT]; // R4
      irq_fn_nxt = reg_wr_data[jmic_pkg::CTRL_IRQ_FN_BIT];
      if (reg_wr_data[jmic_pkg::CTRL_SRST_BIT]) begin
        srst_cnt_nxt = jmic_pkg::SRST_CYCLES; // R10
      end
    end else if (reg_wr_strobe) begin
      unique case (reg_ptr)
        jmic_pkg::ADDR_LEFT: left_nxt = reg_wr_data;
        jmic_pkg::ADDR_RIGHT: right_nxt = reg_wr_data;
        jmic_pkg::ADDR_TOP: top_nxt = reg_wr_data;
        jmic_pkg::ADDR_BOTTOM: bottom_nxt = reg_wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle_r <= jmic_pkg::CTRL_RESET[jmic_pkg::CTRL_IDLE_BIT];
      tb_r <= jmic_pkg::CTRL_RESET[jmic_pkg::CTRL_TB_HI:jmic_pkg::CTRL_TB_LO];
      irq_dis_r <= jmic_pkg::CTRL_RESET[jmic_pkg::CTRL_IRQ_DIS_BIT];
      irq_fn_r <= jmic_pkg::CTRL_RESET[jmic_pkg::CTRL_IRQ_FN_BIT];
      left_r <= jmic_pkg::LEFT_RESET;
      right_r <= jmic_pkg::RIGHT_RESET;
      top_r <= jmic_pkg::TOP_RESET;
      bottom_r <= jmic_pkg::BOTTOM_RESET;
      srst_cnt_r <= 3'h0;
    end else begin
      idle_r <= idle_nxt;
      tb_r <= tb_nxt;
      irq_dis_r <= irq_dis_nxt;
      irq_fn_r <= irq_fn_nxt;
      left_r <= left_nxt;
      right_r <= right_nxt;
      top_r <= top_nxt;
      bottom_r <= bottom_nxt;
      srst_cnt_r <= srst_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // measurement pacing, coordinates and interrupt
  // ----------------------------------------------------------------
  // a start while a conversion runs is dropped; the front end has one slot
  always_comb begin
    meas_nxt = meas_r;
    start_nxt = 1'b0;
    boot_nxt = boot_r;
    x_nxt = x_r;
    y_nxt = y_r;
    valid_nxt = valid_r;
    irq_nxt = irq_r;
    pend_nxt = pend_r;
    dly_nxt = dly_r;
    irq_event = 1'b0;
    if (dly_r != '0) begin
      dly_nxt = dly_r - 17'd1;
    end
    // R6: readout acknowledge clears, an event in the same cycle wins below
    if (y_read_ack) begin
      irq_nxt = 1'b0;
      if (idle_r) begin
        dly_nxt = IRQ_DELAY_CYCLES[jmic_pkg::TICK_W-1:0]; // R5
      end
    end
    unique case (meas_r)
      jmic_pkg::JMIC_MEAS_IDLE: begin
        if ((idle_r && (y_read_ack || boot_r)) || (!idle_r && wake)) begin // R1 R2
          meas_nxt = jmic_pkg::JMIC_MEAS_BUSY;
          start_nxt = 1'b1;
          boot_nxt = 1'b0;
          valid_nxt = 1'b0; // R11
        end
      end
      jmic_pkg::JMIC_MEAS_BUSY: begin
        if (meas_done) begin
          meas_nxt = jmic_pkg::JMIC_MEAS_IDLE;
          x_nxt = meas_x; // R14
          y_nxt = meas_y;
          valid_nxt = 1'b1; // R12
          if (irq_fn_r) begin
            irq_event = outside; // R7 R8
          end else if (idle_r) begin
            pend_nxt = 1'b1; // R5
          end else begin
            irq_event = 1'b1; // R5
          end
        end
      end
    endcase
    // idle mode with function bit 0 waits for the readout delay before flagging the result
    if (pend_r && (dly_r == '0)) begin
      pend_nxt = 1'b0;
      irq_event = 1'b1; // R5
    end
    if (irq_event) begin
      irq_nxt = 1'b1;
    end
    if (soft_clr) begin
      meas_nxt = jmic_pkg::JMIC_MEAS_IDLE;
      start_nxt = 1'b0;
      boot_nxt = 1'b1;
      x_nxt = jmic_pkg::COORD_RESET;
      y_nxt = jmic_pkg::COORD_RESET;
      valid_nxt = jmic_pkg::CTRL_RESET[jmic_pkg::CTRL_VALID_BIT];
      irq_nxt = 1'b0;
      pend_nxt = 1'b0;
      dly_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meas_r <= jmic_pkg::JMIC_MEAS_IDLE;
      start_r <= 1'b0;
      boot_r <= 1'b1;
      x_r <= jmic_pkg::COORD_RESET;
      y_r <= jmic_pkg::COORD_RESET;
      valid_r <= jmic_pkg::CTRL_RESET[jmic_pkg::CTRL_VALID_BIT];
      irq_r <= 1'b0;
      pend_r <= 1'b0;
      dly_r <= '0;
    end else begin
      meas_r <= meas_nxt;
      start_r <= start_nxt;
      boot_r <= boot_nxt;
      x_r <= x_nxt;
      y_r <= y_nxt;
      valid_r <= valid_nxt;
      irq_r <= irq_nxt;
      pend_r <= pend_nxt;
      dly_r <= dly_nxt;
    end
  end

  // ----------------------------------------------------------------
  // snapshot, read data and pin
  // ----------------------------------------------------------------
  // snapshot follows live values only while the pointer is elsewhere,
  // so a block read of 0F..11 sees one consistent conversion
  always_comb begin
    snap_ctrl_nxt = snap_ctrl_r;
    snap_x_nxt = snap_x_r;
    snap_y_nxt = snap_y_r;
    if (!frozen) begin // R13
      snap_ctrl_nxt = ctrl_live;
      snap_x_nxt = x_r;
      snap_y_nxt = y_r;
    end
    rd_hit_nxt = 1'b1;
    unique case (reg_ptr)
      jmic_pkg::ADDR_CTRL: rd_data_nxt = snap_ctrl_r;
      jmic_pkg::ADDR_X: rd_data_nxt = snap_x_r;
      jmic_pkg::ADDR_Y: rd_data_nxt = snap_y_r;
      jmic_pkg::ADDR_LEFT: rd_data_nxt = left_r;
      jmic_pkg::ADDR_RIGHT: rd_data_nxt = right_r;
      jmic_pkg::ADDR_TOP: rd_data_nxt = top_r;
      jmic_pkg::ADDR_BOTTOM: rd_data_nxt = bottom_r;
      default: begin
        rd_data_nxt = 8'h00;
        rd_hit_nxt = 1'b0;
      end
    endcase
    oe_n_nxt = !(irq_r && !irq_dis_r); // R4
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snap_ctrl_r <= jmic_pkg::CTRL_RESET;
      snap_x_r <= jmic_pkg::COORD_RESET;
      snap_y_r <= jmic_pkg::COORD_RESET;
      rd_data_r <= 8'h00;
      rd_hit_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      snap_ctrl_r <= snap_ctrl_nxt;
      snap_x_r <= snap_x_nxt;
      snap_y_r <= snap_y_nxt;
      rd_data_r <= rd_data_nxt;
      rd_hit_r <= rd_hit_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign reg_rd_data = rd_data_r;
  assign reg_rd_hit = rd_hit_r;
  assign meas_start = start_r;
  assign motion_irq_n_o = 1'b0; // open drain: only ever pulls low
  assign motion_irq_n_oe_n = oe_n_r;

endmodule : jmic_control

// file: testbench/jmic_control_asserts.sv
// port checker for the joystick measurement and interrupt control block
// assumes one clock domain and a bind onto jmic_control
`timescale 1ns/1ns
module jmic_control_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_ptr,
  input wire logic reg_wr_strobe,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_hit,
  input wire logic y_read_ack,
  input wire logic meas_start,
  input wire logic meas_done,
  input wire logic motion_irq_n_o,
  input wire logic motion_irq_n_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic dis_r, dis_nxt, busy_r, busy_nxt;
  // shadow of the disable bit; a soft reset write clears it, so it wins
  always_comb begin
    dis_nxt = dis_r;
    busy_nxt = (busy_r | meas_start) & ~meas_done;
    if (reg_wr_strobe && reg_ptr == 8'h0F) begin
      dis_nxt = reg_wr_data[3] & ~reg_wr_data[1];
    end
  end
  // helper registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dis_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      dis_r <= dis_nxt;
      busy_r <= busy_nxt;
    end
  end
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
    !meas_start && motion_irq_n_oe_n && !reg_rd_hit && reg_rd_data == 8'h00)
    else $error("outputs not quiet after reset");
  a_boot_start: assert property ($fell(sys_rst) |-> ##[0:3] meas_start)
    else $error("no boot measurement");
  a_start_pulse: assert property (meas_start |=> !meas_start)
    else $error("start pulse too long");
  a_no_restart: assert property (meas_start |-> !busy_r)
    else $error("start while converting");
  a_hit_decode: assert property (!$past(sys_rst) |->
    reg_rd_hit == ($past(reg_ptr) >= 8'h0F && $past(reg_ptr) <= 8'h15))
    else $error("read hit decode wrong");
  a_miss_zero: assert property (!reg_rd_hit |-> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_ack_release: assert property (y_read_ack && !meas_done ##1 !meas_done |-> ##1 motion_irq_n_oe_n)
    else $error("interrupt not released after ack");
  a_dis_release: assert property (dis_r && $past(dis_r) && $past(dis_r, 2) |-> motion_irq_n_oe_n)
    else $error("pin driven while disabled");
  a_pin_low: assert property (motion_irq_n_o == 1'b0)
    else $error("pin data not low");
  c_start: cover property (meas_start);
  c_irq: cover property ($fell(motion_irq_n_oe_n));
  c_clear: cover property (y_read_ack ##2 motion_irq_n_oe_n);
  c_srst: cover property (reg_wr_strobe && reg_wr_data[1]);
endmodule : jmic_control_asserts
bind jmic_control jmic_control_asserts u_jmic_control_asserts (.clk(clk), .sys_rst(sys_rst),
  .reg_ptr(reg_ptr), .reg_wr_strobe(reg_wr_strobe), .reg_wr_data(reg_wr_data),
  .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit), .y_read_ack(y_read_ack),
  .meas_start(meas_start), .meas_done(meas_done), .motion_irq_n_o(motion_irq_n_o),
  .motion_irq_n_oe_n(motion_irq_n_oe_n));

// file: testbench/jmic_front_model.sv
// behavioural hall front end: answers each start after a set delay
// assumes starts arrive on clk and never while a conversion runs
`timescale 1ns/1ns
module jmic_front_model (
  input wire logic clk,
  input wire logic meas_start,
  input wire logic [7:0] set_x,
  input wire logic [7:0] set_y,
  input wire logic [7:0] dly,
  output logic meas_done,
  output logic [7:0] meas_x,
  output logic [7:0] meas_y
);
  int cnt = 0;
  initial begin
    meas_done = 1'b0;
    meas_x = 8'h00;
    meas_y = 8'h00;
  end
  // results valid only with done; otherwise toggling so a stale capture shows
  always @(posedge clk) begin
    meas_done <= 1'b0;
    meas_x <= ~meas_x;
    meas_y <= ~meas_y;
    if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    if (cnt == 1) begin
      meas_done <= 1'b1;
      meas_x <= set_x;
      meas_y <= set_y;
    end
    if (meas_start) begin
      cnt <= int'(dly);
    end
  end
endmodule : jmic_front_model

// file: testbench/tb_jmic_control.sv
// self-checking bench for jmic_control with a behavioural front end
// assumes shortened counts: 10 cycles per ms tick, 20 cycles irq delay
`timescale 1ns/1ns
module tb_jmic_control;
  // ----------------------------------------------------------------
  // bench setup
  // ----------------------------------------------------------------
  localparam int MS_T = 10;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_ptr = 8'h00;
  logic reg_wr_strobe = 1'b0;
  logic [7:0] reg_wr_data = 8'h00;
  logic y_read_ack = 1'b0;
  logic [7:0] set_x = 8'h00;
  logic [7:0] set_y = 8'h00;
  logic [7:0] dly = 8'h05;
  logic [7:0] reg_rd_data, meas_x, meas_y, rd_v;
  logic reg_rd_hit, meas_start, meas_done, motion_irq_n_o, motion_irq_n_oe_n;
  int err_count = 0;
  int checks_done = 0;
  int n;
  always #5 clk = ~clk;
  jmic_control #(.MS_TICK_CYCLES(MS_T), .IRQ_DELAY_CYCLES(20)) u_jmic_control (.clk(clk),
    .sys_rst(sys_rst), .reg_ptr(reg_ptr), .reg_wr_strobe(reg_wr_strobe), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit), .y_read_ack(y_read_ack),
    .meas_start(meas_start), .meas_done(meas_done), .meas_x(meas_x), .meas_y(meas_y),
    .motion_irq_n_o(motion_irq_n_o), .motion_irq_n_oe_n(motion_irq_n_oe_n));
  jmic_front_model u_jmic_front_model (.clk(clk), .meas_start(meas_start), .set_x(set_x),
    .set_y(set_y), .dly(dly), .meas_done(meas_done), .meas_x(meas_x), .meas_y(meas_y));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_ptr = a;
    reg_wr_data = d;
    reg_wr_strobe = 1'b1;
    @(negedge clk);
    reg_wr_strobe = 1'b0;
    reg_ptr = 8'h00;
  endtask : wr
  // park the pointer first so the snapshot is fresh when it lands
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_ptr = 8'h00;
    cyc(2);
    reg_ptr = a;
    cyc(1);
    rd_v = reg_rd_data;
  endtask : rd
  task automatic ack();
    @(negedge clk);
    y_read_ack = 1'b1;
    @(negedge clk);
    y_read_ack = 1'b0;
  endtask : ack
  task automatic wait_start(input int lim, output int c);
    c = 0;
    while (meas_start !== 1'b1 && c < lim) begin
      @(negedge clk);
      c++;
    end
  endtask : wait_start
  // one dead zone sample: wait for the wake start, clear, compare pin with expectation
  task automatic dz_step(input logic [7:0] x, input logic [7:0] y, input logic out);
    set_x = x;
    set_y = y;
    wait_start(400, n);
    chk("dz wake", 16'h1, 16'(n < 400));
    ack();
    cyc(2);
    chk("irq cleared", 16'h1, motion_irq_n_oe_n);
    cyc(6);
    chk("dead zone pin", 16'(!out), motion_irq_n_oe_n);
  endtask : dz_step
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] rv[4] = '{8'h05, 8'hFB, 8'h05, 8'hFB};
    cyc(20);
    rd(8'h0F);
    chk("ctrl reset", 16'hF1, rd_v);
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'h12 + i));
      chk("threshold reset", 16'(rv[i]), rd_v);
    end
    wr(8'h20, 8'h5A);
    rd(8'h20);
    chk("unmapped", 16'h00, rd_v);
  endtask : t_reset
  task automatic t_idle();
    dly = 8'd30;
    set_x = 8'h03;
    set_y = 8'hFE;
    ack();
    wait_start(10, n);
    // start already stands at the negedge that ends the ack pulse
    chk("ack to start", 16'h0, 16'(n));
    rd(8'h0F);
    chk("valid busy", 16'h0, 16'(rd_v[0]));
    ack();
    wait_start(40, n);
    chk("busy refuse", 16'd40, 16'(n));
    rd(8'h10);
    chk("x", 16'h03, rd_v);
    rd(8'h11);
    chk("y", 16'hFE, rd_v);
    rd(8'h0F);
    chk("valid done", 16'hF1, rd_v);
    dly = 8'd5;
    ack();
    cyc(2);
    chk("irq clear", 16'h1, motion_irq_n_oe_n);
    cyc(10);
    chk("irq early", 16'h1, motion_irq_n_oe_n);
    cyc(15);
    chk("irq late", 16'h0, motion_irq_n_oe_n);
    cyc(50);
    chk("irq held", 16'h0, motion_irq_n_oe_n);
    reg_ptr = 8'h10;
    set_x = 8'h44;
    ack();
    cyc(40);
    chk("x frozen", 16'h03, reg_rd_data);
    rd(8'h10);
    chk("x fresh", 16'h44, rd_v);
  endtask : t_idle
  task automatic t_lowpower();
    int ms[8] = '{20, 40, 80, 100, 140, 200, 260, 320};
    for (int i = 0; i < 8; i++) begin
      wr(8'h0F, 8'hF0);
      wr(8'h0F, {1'b0, 3'(i), 4'h0});
      wait_start(4000, n);
      cyc(1);
      wait_start(4000, n);
      chk("wake interval", 16'(ms[i] * MS_T), 16'(n + 1));
    end
    ack();
    cyc(2);
    chk("lp irq clear", 16'h1, motion_irq_n_oe_n);
    cyc(5);
    chk("lp irq", 16'h0, motion_irq_n_oe_n);
  endtask : t_lowpower
  task automatic t_deadzone();
    logic [7:0] xs[8] = '{8'h05, 8'h06, 8'hFA, 8'hFB, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ys[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h06, 8'hFA, 8'hFB};
    logic os[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    wr(8'h0F, 8'hF0);
    wr(8'h0F, 8'h04);
    for (int i = 0; i < 8; i++) begin
      dz_step(xs[i], ys[i], os[i]);
    end
    wr(8'h13, 8'h80);
    dz_step(8'h80, 8'h00, 1'b0);
    wr(8'h0F, 8'h0C);
    set_x = 8'h06;
    wait_start(400, n);
    cyc(10);
    chk("irq disabled", 16'h1, motion_irq_n_oe_n);
    wr(8'h0F, 8'h04);
    cyc(3);
    chk("irq enabled", 16'h0, motion_irq_n_oe_n);
  endtask : t_deadzone
  task automatic t_softrst();
    wr(8'h0F, 8'hF0);
    cyc(20);
    wr(8'h12, 8'h20);
    rd(8'h12);
    chk("left write", 16'h20, rd_v);
    wr(8'h0F, 8'h0A);
    cyc(30);
    rd(8'h0F);
    chk("ctrl soft", 16'hF1, rd_v);
    rd(8'h12);
    chk("left soft", 16'h05, rd_v);
    // dead zone in idle mode flags at the result, no readout delay
    wr(8'h0F, 8'h84);
    set_x = 8'h06;
    ack();
    cyc(1);
    chk("idle dz clear", 16'h1, motion_irq_n_oe_n);
    cyc(9);
    chk("idle dz irq", 16'h0, motion_irq_n_oe_n);
  endtask : t_softrst
  initial begin
    cyc(6);
    sys_rst = 1'b0;
    t_reset();
    t_idle();
    t_lowpower();
    t_deadzone();
    t_softrst();
    close_out();
  end
  // watchdog sized well above the longest wake sweep
  initial begin
    #800000;
    err_count++;
    close_out();
  end
endmodule : tb_jmic_control
